/* rtl/level_synchroniser.sv */
`timescale 1ns/1ps
`default_nettype none
module level_synchroniser #(
  parameter int               WIDTH       = 2,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one;

  // ==========================================================
  // Two flops; first stage feeds only the second
  always_ff @(posedge clock) begin
    if (rst) begin
      stage_one <= RESET_VALUE;
      sync_out  <= RESET_VALUE;
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end

endmodule : level_synchroniser
`default_nettype wire

/* rtl/scc_bank_pkg.sv */
// Behaviour
// - Acknowledging party holds the data line low during the ninth clock high.
// - After an unacknowledged read byte, the target releases the data line.
// - A read without a pointer write starts at the first register.
// - Event source register holds latched events in the fixed bit order.
// - Reading the event source register returns it, then clears it.
// - Thermal comparator trips set the three thermal event bits.
// - Mask register: one bit per source, 1 masks, resets to zero.
// - Read-only live status register; bits 4 and 0 read zero.
// - Overcurrent warning status is 1 while current is at alarm level.
// - Converter enable bit 0 of 0x03, resets off, upper bits reserved.
// - Bit 0 of 0x04 selects skip mode (0) or fixed rate (1).
// - Spread field bits 5:4 of 0x05 select dithering, reset value 11.
// - Reserved bits always read back zero.
// - Target answers at seven-bit address 1101000 for reads and writes.
// - Reaching alarm current sets both the warning event and status bit.
// - Warning status clears only below the lower release level.
// - Soft-start timeout sets the fault event and returns to standby.
package converter_bank_pkg;

  // ==========================================================
  // Bus address and register map
  localparam logic [6:0] TARGET_ADDR = 7'h68;
  localparam int         REG_COUNT   = 23;
  localparam logic [7:0] ADDR_INT_SOURCE = 8'h00;
  localparam logic [7:0] ADDR_INT_MASK   = 8'h01;
  localparam logic [7:0] ADDR_LIVE       = 8'h02;
  localparam logic [7:0] ADDR_CONV_EN    = 8'h03;
  localparam logic [7:0] ADDR_CFG_A      = 8'h04;
  localparam logic [7:0] ADDR_CFG_B      = 8'h05;
  localparam logic [7:0] ADDR_VIN_LIM    = 8'h06;
  localparam logic [7:0] ADDR_OC_PRI     = 8'h07;
  localparam logic [7:0] ADDR_OC_SEC     = 8'h08;
  localparam logic [7:0] ADDR_OUT_OV     = 8'h09;
  localparam logic [7:0] ADDR_SOFTSTART  = 8'h0A;
  localparam logic [7:0] ADDR_PIN_CFG_A  = 8'h0B;
  localparam logic [7:0] ADDR_PIN_CFG_B  = 8'h0C;
  localparam logic [7:0] ADDR_PORT_CFG   = 8'h14;
  localparam logic [7:0] ADDR_REVISION   = 8'h15;
  localparam logic [7:0] ADDR_PART_ID    = 8'h16;

  // ==========================================================
  // Field positions
  localparam int BIT_CONV_ON     = 0;
  localparam int BIT_FIXED_RATE  = 0;
  localparam int SPREAD_LSB      = 4;
  localparam int RATE_LSB        = 0;

  // ==========================================================
  // Timing
  localparam longint CLOCK_HZ      = 100_000_000;
  localparam longint SS_TIMEOUT_MS = 120;
  localparam int SOFTSTART_CYCLES_DEF = int'(SS_TIMEOUT_MS * CLOCK_HZ / 64'd1000);

  // ==========================================================
  // Types
  typedef struct packed {
    logic input_overvoltage;
    logic output_overvoltage;
    logic current_at_alarm;      // At or above alarm fraction
    logic current_above_release; // At or above release fraction
    logic overcurrent_trip;
    logic thermal_one;
    logic thermal_two;
    logic thermal_cutoff;
    logic output_near_half;
  } condition_s;
  localparam int COND_W = $bits(condition_s);

  typedef struct packed {
    logic       converter_on;
    logic       constant_rate_select;
    logic [1:0] spread_select;
    logic [2:0] switching_rate_select;
  } converter_ctrl_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK  = 3'b011,
    ST_RX   = 3'b010,
    ST_TX   = 3'b110,
    ST_TACK = 3'b111,
    ST_WAIT = 3'b101
  } link_state_e;

  // ==========================================================
  // Writable bits and reset values per register
  function automatic logic [7:0] reg_mask(input logic [7:0] a);
    case (a)
      ADDR_INT_MASK:  reg_mask = 8'hFF;
      ADDR_CONV_EN:   reg_mask = 8'h01;
      ADDR_CFG_A:     reg_mask = 8'h11;
      ADDR_CFG_B:     reg_mask = 8'h37;
      ADDR_VIN_LIM:   reg_mask = 8'h33;
      ADDR_OC_PRI:    reg_mask = 8'h9F;
      ADDR_OC_SEC:    reg_mask = 8'h0F;
      ADDR_OUT_OV:    reg_mask = 8'h1F;
      ADDR_SOFTSTART: reg_mask = 8'h37;
      ADDR_PIN_CFG_A: reg_mask = 8'h87;
      ADDR_PIN_CFG_B: reg_mask = 8'hB7;
      ADDR_PORT_CFG:  reg_mask = 8'h11;
      default:        reg_mask = 8'h00;
    endcase
  endfunction : reg_mask

  function automatic logic [7:0] reg_reset(input logic [7:0] a);
    case (a)
      ADDR_CFG_A:     reg_reset = 8'h10;
      ADDR_CFG_B:     reg_reset = 8'h31;
      ADDR_OC_PRI:    reg_reset = 8'h97;
      ADDR_OC_SEC:    reg_reset = 8'h0D;
      ADDR_OUT_OV:    reg_reset = 8'h12;
      ADDR_SOFTSTART: reg_reset = 8'h31;
      ADDR_PIN_CFG_A: reg_reset = 8'h82;
      ADDR_PIN_CFG_B: reg_reset = 8'h26;
      default:        reg_reset = 8'h00;
    endcase
  endfunction : reg_reset

endpackage : converter_bank_pkg

/* rtl/scc_register_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module converter_serial_register_bank
  import converter_bank_pkg::*;
#(
  parameter int         SOFTSTART_CYCLES = SOFTSTART_CYCLES_DEF,
  parameter logic [7:0] REVISION         = 8'h11, // Arbitrary value
  parameter logic [7:0] PART_ID          = 8'h5A  // Arbitrary value
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Serial bus pins
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  // Comparator levels
  input  wire condition_s conditions,
  // Converter controls
  output converter_ctrl_s ctrl,
  output logic            interrupt_out_n
);

  localparam int SS_W = $clog2(SOFTSTART_CYCLES + 1);

  // ==========================================================
  // Synchronised inputs
  logic [COND_W+1:0] sync_bus;
  logic              scl_s;
  logic              sda_s;
  condition_s        cond_s;
  logic              scl_q;
  logic              sda_q;
  condition_s        cond_q;

  // Pins idle high, so their stages reset high; no false edge after reset
  level_synchroniser #(
    .WIDTH       (COND_W + 2),
    .RESET_VALUE ({2'b11, {COND_W{1'b0}}})
  ) u_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in ({scl, sda_in, conditions}),
    .sync_out (sync_bus)
  );

  assign {scl_s, sda_s, cond_s} = sync_bus;

  // Previous samples for edge detection
  always_ff @(posedge clock) begin
    if (rst) begin
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      cond_q <= '0;
    end else begin
      scl_q  <= scl_s;
      sda_q  <= sda_s;
      cond_q <= cond_s;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  // Bus events; data edges count only while clock is high
  assign scl_rise   = scl_s & ~scl_q;
  assign scl_fall   = ~scl_s & scl_q;
  assign start_seen = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_seen  = scl_s & scl_q & ~sda_q & sda_s;

  // ==========================================================
  // Register storage
  logic [7:0] bank [0:REG_COUNT-1];
  logic [7:0] src;
  logic [7:0] live;
  logic       oc_warn_flag;
  logic [7:0] ptr;
  logic [7:0] rd_value;
  logic       in_map;
  logic [4:0] idx;
  logic       wr_pulse;
  logic [7:0] wr_data;
  logic       src_clear;
  logic       ss_fault;

  assign in_map = (ptr < 8'(REG_COUNT));
  assign idx    = ptr[4:0];

  // Live levels; unused positions tied low
  assign live = {cond_s.input_overvoltage,
                 cond_s.output_overvoltage,
                 oc_warn_flag,
                 1'b0,
                 cond_s.thermal_one,
                 cond_s.thermal_two,
                 cond_s.thermal_cutoff,
                 1'b0};

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_value = 8'h00;
    if (ptr == ADDR_INT_SOURCE) begin
      rd_value = src;
    end else if (ptr == ADDR_LIVE) begin
      rd_value = live;
    end else if (ptr == ADDR_REVISION) begin
      rd_value = REVISION;
    end else if (ptr == ADDR_PART_ID) begin
      rd_value = PART_ID;
    end else if (in_map) begin
      rd_value = bank[idx] & reg_mask(ptr);
    end
  end

  // ==========================================================
  // Serial target state machine
  link_state_e state;
  logic [7:0]  shift;
  logic [3:0]  bit_cnt;
  logic        is_read;
  logic        ptr_set;
  logic        expect_ptr;

  always_ff @(posedge clock) begin
    if (rst) begin
      state      <= ST_IDLE;
      shift      <= 8'h00;
      bit_cnt    <= 4'h0;
      is_read    <= 1'b0;
      ptr_set    <= 1'b0;
      expect_ptr <= 1'b0;
      ptr        <= 8'h00;
      sda_oe_n   <= 1'b1;
      wr_pulse   <= 1'b0;
      wr_data    <= 8'h00;
      src_clear  <= 1'b0;
    end else begin
      wr_pulse  <= 1'b0;
      src_clear <= 1'b0;
      if (stop_seen) begin
        // Pointer forgets itself between transactions
        state    <= ST_IDLE;
        ptr_set  <= 1'b0;
        sda_oe_n <= 1'b1;
      end else if (start_seen) begin
        state    <= ST_ADDR;
        bit_cnt  <= 4'h0;
        sda_oe_n <= 1'b1;
      end else begin
        unique case (state)
          ST_IDLE, ST_WAIT: begin
            sda_oe_n <= 1'b1;
          end
          ST_ADDR, ST_RX: begin
            if (scl_rise && bit_cnt != 4'h8) begin
              shift   <= {shift[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              bit_cnt <= 4'h0;
              if (state == ST_ADDR) begin
                if (shift[7:1] == TARGET_ADDR) begin
                  is_read    <= shift[0];
                  expect_ptr <= ~shift[0];
                  if (shift[0] && !ptr_set) begin
                    ptr <= ADDR_INT_SOURCE;
                  end
                  state    <= ST_ACK;
                  sda_oe_n <= 1'b0;
                end else begin
                  state <= ST_WAIT;
                end
              end else begin
                if (expect_ptr) begin
                  ptr        <= shift;
                  ptr_set    <= 1'b1;
                  expect_ptr <= 1'b0;
                end else begin
                  wr_pulse <= 1'b1;
                  wr_data  <= shift;
                end
                state    <= ST_ACK;
                sda_oe_n <= 1'b0;
              end
            end
          end
          ST_ACK: begin
            // Low drive holds through the whole clock-high phase
            if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (is_read) begin
                shift     <= rd_value;
                sda_oe_n  <= rd_value[7];
                src_clear <= (ptr == ADDR_INT_SOURCE);
                ptr       <= ptr + 8'h01;
                state     <= ST_TX;
              end else begin
                sda_oe_n <= 1'b1;
                state    <= ST_RX;
              end
            end else if (wr_pulse) begin
              ptr <= ptr + 8'h01;
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt == 4'h7) begin
                sda_oe_n <= 1'b1;  // Free the line for host answer
                state    <= ST_TACK;
              end else begin
                shift    <= {shift[6:0], 1'b0};
                sda_oe_n <= shift[6];
                bit_cnt  <= bit_cnt + 4'h1;
              end
            end
          end
          ST_TACK: begin
            if (scl_rise) begin
              if (sda_s) begin
                state    <= ST_WAIT;
                sda_oe_n <= 1'b1;
              end else begin
                state <= ST_ACK;      // Next byte loads on the fall
              end
            end
          end
          default: begin
            state    <= ST_IDLE;
            sda_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end

  // Open-drain pin only ever pulls low
  always_ff @(posedge clock) begin
    if (rst) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // ==========================================================
  // Writable registers
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        bank[i] <= reg_reset(8'(i));
      end
    end else begin
      if (ss_fault) begin
        bank[ADDR_CONV_EN[4:0]][BIT_CONV_ON] <= 1'b0;
      end
      // A host write in the same cycle takes precedence
      if (wr_pulse && in_map) begin
        bank[idx] <= wr_data & reg_mask(ptr);
      end
    end
  end

  // ==========================================================
  // Overcurrent warning with hysteresis
  always_ff @(posedge clock) begin
    if (rst) begin
      oc_warn_flag <= 1'b0;
    end else if (cond_s.current_at_alarm) begin
      oc_warn_flag <= 1'b1;
    end else if (!cond_s.current_above_release) begin
      oc_warn_flag <= 1'b0;
    end
  end

  // ==========================================================
  // Latched event sources
  logic [7:0] events;

  assign events = {
    cond_s.input_overvoltage  & ~cond_q.input_overvoltage,
    cond_s.output_overvoltage & ~cond_q.output_overvoltage,
    cond_s.current_at_alarm   & ~cond_q.current_at_alarm,
    cond_s.overcurrent_trip   & ~cond_q.overcurrent_trip,
    cond_s.thermal_one        & ~cond_q.thermal_one,
    cond_s.thermal_two        & ~cond_q.thermal_two,
    cond_s.thermal_cutoff     & ~cond_q.thermal_cutoff,
    ss_fault};

  // New events win over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      src <= 8'h00;
    end else begin
      src <= (src & ~{8{src_clear}}) | events;
    end
  end

  // ==========================================================
  // Soft-start supervision
  logic            ss_active;
  logic [SS_W-1:0] ss_count;
  logic            en_q;
  logic            conv_on_bit;

  assign conv_on_bit = bank[ADDR_CONV_EN[4:0]][BIT_CONV_ON];

  // Timer restarts on each enable; output near half stops it
  always_ff @(posedge clock) begin
    if (rst) begin
      ss_active <= 1'b0;
      ss_count  <= '0;
      ss_fault  <= 1'b0;
      en_q      <= 1'b0;
    end else begin
      en_q     <= conv_on_bit;
      ss_fault <= 1'b0;
      if (!conv_on_bit) begin
        ss_active <= 1'b0;
      end else if (!en_q) begin
        ss_active <= 1'b1;
        ss_count  <= '0;
      end else if (ss_active) begin
        if (cond_s.output_near_half) begin
          ss_active <= 1'b0;
        end else if (ss_count == SS_W'(SOFTSTART_CYCLES - 1)) begin
          ss_active <= 1'b0;
          ss_fault  <= 1'b1;
        end else begin
          ss_count <= ss_count + SS_W'(1);
        end
      end
    end
  end

  // ==========================================================
  // Registered outputs
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl            <= '0;
      interrupt_out_n <= 1'b1;
    end else begin
      ctrl.converter_on <= conv_on_bit;
      ctrl.constant_rate_select <=
        bank[ADDR_CFG_A[4:0]][BIT_FIXED_RATE];
      ctrl.spread_select <=
        bank[ADDR_CFG_B[4:0]][SPREAD_LSB +: 2];
      ctrl.switching_rate_select <=
        bank[ADDR_CFG_B[4:0]][RATE_LSB +: 3];
      interrupt_out_n <=
        ~|(src & ~bank[ADDR_INT_MASK[4:0]]);
    end
  end

endmodule : converter_serial_register_bank
`default_nettype wire

/* test/converter_serial_register_bank_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module bank_checker
  import converter_bank_pkg::*;
(
  // Clock and reset
  input wire logic            clock,
  input wire logic            rst,
  // Bus pins
  input wire logic            scl,
  input wire logic            sda_in,
  input wire logic            sda_out,
  input wire logic            sda_oe_n,
  // Levels and controls
  input wire condition_s      conditions,
  input wire converter_ctrl_s ctrl,
  input wire logic            interrupt_out_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ====
  // Pin history and address byte tracker
  logic       scl_q;
  logic       sda_q;
  logic       first;
  logic [3:0] cnt;
  logic [7:0] shreg;
  wire        rise      = scl && !scl_q;
  wire        start_det = scl && scl_q && sda_q && !sda_in;
  always_ff @(posedge clock) begin
    scl_q <= scl;
    sda_q <= sda_in;
  end
  // Only the first byte after a start; data bytes are judged by the bench
  always_ff @(posedge clock) begin
    if (rst) begin
      first <= 1'b0;
      cnt   <= 4'h0;
    end else if (start_det) begin
      first <= 1'b1;
      cnt   <= 4'h0;
    end else if (rise && first) begin
      cnt   <= cnt + 4'h1;
      shreg <= {shreg[6:0], sda_in};
      if (cnt == 4'h8) first <= 1'b0;
    end
  end
  // ====
  // Properties
  sda_drive_low_a: assert property (sda_out == 1'b0)
    else $error("data pin drive value not low");
  ack_hold_a: assert property (scl |-> $stable(sda_oe_n))
    else $error("data drive changed while bus clock high");
  answer_time_a: assert property ($changed(sda_oe_n) |-> !scl && !$past(scl)
    && !$past(scl, 2) && ($past(scl, 3) || $past(scl, 4) || $past(scl, 5) || $past(scl, 6)))
    else $error("data drive changed outside its slot after a clock fall");
  addr_ack_a: assert property (first && rise && cnt == 4'h8
    |-> sda_oe_n == (shreg[7:1] != TARGET_ADDR))
    else $error("address byte acknowledge wrong");
  reset_idle_a: assert property ($fell(rst) |-> sda_oe_n && interrupt_out_n)
    else $error("outputs not idle after reset");
  ctrl_reset_a: assert property ($fell(rst) |-> ##2 ctrl == 7'b0011001)
    else $error("control reset value wrong");
  cfg_bus_only_a: assert property (!$past(rst, 2) && !$stable({ctrl.constant_rate_select,
    ctrl.spread_select, ctrl.switching_rate_select}) |-> !scl)
    else $error("configuration changed outside a bus write");
  int_clear_a: assert property ($rose(interrupt_out_n) |-> !scl)
    else $error("interrupt released outside a bus access");
endmodule : bank_checker
`default_nettype wire

/* test/converter_serial_register_bank_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module converter_serial_register_bank_tb_top import converter_bank_pkg::*;;
  localparam logic [6:0] BUS_ADDR  = 7'b1101000;
  localparam logic [7:0] REV_ID    = 8'h3C; // Arbitrary value
  localparam logic [7:0] PART_CODE = 8'hA5; // Arbitrary value
  logic clock, rst, scl, sda_rel, sda_out, sda_oe_n, interrupt_out_n, warn;
  wire  sda_line = sda_oe_n & sda_rel; // Pull-up, either side pulls low
  condition_s      conditions;
  converter_ctrl_s ctrl;
  int              n_fail, samples_checked;
  logic [7:0]      exp_src, q[$], mdl[23];
  logic [7:0] wm[23] = '{8'h00, 8'hFF, 8'h00, 8'h01, 8'h11, 8'h37, 8'h33, 8'h9F, 8'h0F, 8'h1F,
    8'h37, 8'h87, 8'hB7, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h11, 8'h00, 8'h00};
  logic [7:0] rv[23] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h31, 8'h00, 8'h97, 8'h0D, 8'h12,
    8'h31, 8'h82, 8'h26, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, REV_ID, PART_CODE};
  condition_s hy[3] = '{9'h060, 9'h020, 9'h000};
  // ====
  // Design, host and clock
  converter_serial_register_bank #(.SOFTSTART_CYCLES(50), .REVISION(REV_ID),
    .PART_ID(PART_CODE)) DUT (
    .clock(clock), .rst(rst), .scl(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .conditions(conditions), .ctrl(ctrl), .interrupt_out_n(interrupt_out_n));
  host_bus_model host (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_rel(sda_rel));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // ====
  // Model helpers: event bits, live flags, checks
  function automatic logic [7:0] ev(input condition_s c);
    return {c.input_overvoltage, c.output_overvoltage, c.current_at_alarm, c.overcurrent_trip,
      c.thermal_one, c.thermal_two, c.thermal_cutoff, 1'b0};
  endfunction : ev
  function automatic logic [7:0] live();
    return (ev(conditions) & 8'hCE) | {2'b00, warn, 5'b0};
  endfunction : live
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  task automatic set_cond(input condition_s c);
    exp_src |= ev(c) & ~ev(conditions);
    if (c.current_at_alarm) warn = 1'b1;
    else if (!c.current_above_release) warn = 1'b0;
    @(posedge clock);
    conditions <= c;
    repeat (8) @(posedge clock);
    `CHK(interrupt_out_n, ~|(exp_src & ~mdl[1]))
  endtask : set_cond
  // ====
  // Bus transactions
  task automatic bus_write(input logic [7:0] ptr, input logic [7:0] d[$]);
    logic a;
    host.start();
    host.wr_byte({BUS_ADDR, 1'b0}, a);
    host.wr_byte(ptr, a);
    `CHK(a, 1'b1)
    foreach (d[i]) begin
      host.wr_byte(d[i], a);
      `CHK(a, 1'b1)
    end
    host.stop();
  endtask : bus_write
  task automatic bus_read(input bit set_ptr, input logic [7:0] ptr, input int n);
    logic       a;
    logic [7:0] b;
    q = {};
    host.start();
    if (set_ptr) begin
      host.wr_byte({BUS_ADDR, 1'b0}, a);
      host.wr_byte(ptr, a);
      host.start();
    end
    host.wr_byte({BUS_ADDR, 1'b1}, a);
    `CHK(a, 1'b1)
    for (int i = 0; i < n; i++) begin
      host.rd_byte(i == n - 1, b);
      q.push_back(b);
    end
    repeat (6) @(posedge clock);
    `CHK(sda_line, 1'b1)
    host.stop();
  endtask : bus_read
  // Source byte read clears the model copy
  task automatic cmp_burst(input int base);
    foreach (q[i]) begin
      `CHK(q[i], base + i == 2 ? live() : (base + i == 0 ? exp_src : mdl[base + i]))
      if (base + i == 0) exp_src = 8'h00;
    end
  endtask : cmp_burst
  // Hang guard, far above the expected run length
  initial begin
    repeat (80000) @(posedge clock);
    n_fail++;
    test_done();
  end
  // ====
  // Main sequence
  initial begin
    logic [7:0] d[$];
    logic       a;
    condition_s c;
    rst = 1'b1;
    conditions = '0;
    exp_src = 8'h00;
    warn = 1'b0;
    mdl = rv;
    void'($urandom(32'hC0A2265D));
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    repeat (6) @(posedge clock);
    bus_read(1'b0, 8'h00, 23);
    cmp_burst(0);
    $display("test reset map done");
    for (int i = 0; i < 23; i++) begin
      d.push_back(8'($urandom) & (i == 3 ? 8'hFE : 8'hFF));
      if (wm[i] != 8'h00) mdl[i] = d[i] & wm[i];
    end
    bus_write(8'h00, d);
    bus_read(1'b1, 8'h00, 23);
    cmp_burst(0);
    `CHK(ctrl, {1'b0, mdl[4][0], mdl[5][5:4], mdl[5][2:0]})
    $display("test random map done");
    for (int k = 0; k < 4; k++) begin
      mdl[1] = 8'($urandom);
      bus_write(8'h01, '{mdl[1]});
      c = condition_s'(9'($urandom));
      c.current_above_release |= c.current_at_alarm;
      set_cond(c);
      bus_read(1'b1, 8'h00, 3);
      cmp_burst(0);
      set_cond('0);
    end
    foreach (hy[k]) begin
      set_cond(hy[k]);
      bus_read(1'b1, 8'h02, 1);
      cmp_burst(2);
    end
    $display("test events done");
    bus_write(8'h03, '{8'h01});
    repeat (60) @(posedge clock);
    exp_src |= 8'h01;
    `CHK(interrupt_out_n, ~|(exp_src & ~mdl[1]))
    bus_read(1'b1, 8'h00, 4);
    cmp_burst(0);
    set_cond(9'h001);
    bus_write(8'h03, '{8'h01});
    mdl[3] = 8'h01;
    repeat (100) @(posedge clock);
    `CHK(ctrl.converter_on, 1'b1)
    bus_read(1'b1, 8'h03, 1);
    cmp_burst(3);
    bus_read(1'b0, 8'h00, 3);
    cmp_burst(0);
    $display("test soft start done");
    host.start();
    host.wr_byte(8'hA0, a);
    `CHK(a, 1'b0)
    host.stop();
    $display("test foreign address done");
    test_done();
  end
endmodule : converter_serial_register_bank_tb_top
bind converter_serial_register_bank bank_checker chk (.clock(clock), .rst(rst), .scl(scl),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .conditions(conditions), .ctrl(ctrl),
  .interrupt_out_n(interrupt_out_n));
`default_nettype wire

/* test/host_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  // Clock
  input  wire logic clock,
  // Bus lines; sda_rel low pulls the data line down
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_rel
);
  // Idle bus, both lines high
  initial begin
    scl     = 1'b1;
    sda_rel = 1'b1;
  end
  // ====
  // One slot: data moves in clock low, sampled mid high; 10 clocks each phase
  task automatic slot(input logic s, output logic r);
    repeat (3) @(posedge clock);
    sda_rel <= s;
    repeat (7) @(posedge clock);
    scl <= 1'b1;
    repeat (5) @(posedge clock);
    r = sda_line;
    repeat (5) @(posedge clock);
  endtask : slot
  // Start or repeated start
  task automatic start();
    logic r;
    slot(1'b1, r);
    sda_rel <= 1'b0;
    repeat (10) @(posedge clock);
    scl <= 1'b0;
  endtask : start
  // Stop ends with both lines released
  task automatic stop();
    logic r;
    slot(1'b0, r);
    sda_rel <= 1'b1;
    repeat (10) @(posedge clock);
  endtask : stop
  task automatic bit_io(input logic b, output logic r);
    slot(b, r);
    scl <= 1'b0;
  endtask : bit_io
  // Byte out, MSB first; ack is a low line in the ninth slot
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : wr_byte
  // Byte in; host pulls low to ack, releases on the last wanted byte
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask : rd_byte
endmodule : host_bus_model
`default_nettype wire
